//--- include/esmb_pkg.sv
// Package: constants and state codes for the external static memory bus
`default_nettype none
package esmb_pkg;
   localparam int ADDR_W          = 16;
   localparam int DATA_W          = 16;
   localparam int BYTE_W          = 8;
   localparam int LANES           = 2;
   // System clock period and bus clock period in ns
   localparam int CLK_SYS_NS      = 10;
   localparam int BUS_CLK_PER_NS  = 40;
   // One phase is half a bus clock period, rounded up to whole cycles
   localparam int PHASE_CYC       =
      (BUS_CLK_PER_NS / 2 + CLK_SYS_NS - 1) / CLK_SYS_NS;
   localparam int PHASE_CNT_W     = 8;
   localparam logic [1:0] LANES_NONE  = 2'h0;
   localparam logic [1:0] STROBE_IDLE = 2'h3;
   localparam logic [15:0] ADDR_RST   = 16'h0000;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_T1    = 4'b0001,
      ST_T2    = 4'b0010,
      ST_W1    = 4'b0011,
      ST_W2    = 4'b0100,
      ST_T3    = 4'b0101,
      ST_T4    = 4'b0110,
      ST_INT1  = 4'b0111,
      ST_INT2  = 4'b1000,
      ST_FLOAT = 4'b1001
   } esmb_state_t;
endpackage
`default_nettype wire

//--- logic/esmb_phase_gen.sv
// Divider: bus clock level and one-cycle phase enables
`default_nettype none
module esmb_phase_gen
   import esmb_pkg::*;
#(
   parameter int PHASE_CYC_P = PHASE_CYC
) (
   input  wire logic clk,
   input  wire logic arst_n,
   output logic      phase_en,
   output logic      bus_clk_high
);
   logic [PHASE_CNT_W-1:0] cnt;
   logic [PHASE_CNT_W-1:0] next_cnt;
   logic                   half_high;
   logic                   next_half_high;

   localparam logic [PHASE_CNT_W-1:0] CNT_LAST =
      PHASE_CNT_W'(PHASE_CYC_P - 1);

   always_comb begin
      next_cnt       = cnt + 1'b1;
      next_half_high = half_high;
      if (cnt == CNT_LAST) begin
         next_cnt       = '0;
         next_half_high = ~half_high;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt       <= '0;
         half_high <= 1'b1;
      end else begin
         cnt       <= next_cnt;
         half_high <= next_half_high;
      end
   end

   // Each half of the bus clock is exactly one phase
   assign phase_en     = (cnt == CNT_LAST);
   assign bus_clk_high = half_high;
endmodule
`default_nettype wire

//--- logic/esmb_ctrl.sv
// External static memory bus sequencer with pin drivers
//
// Contract
// [R1] 16-bit address, separate unmultiplexed data bus
// [R2] Word-wide and byte-wide memory both supported
// [R3] Bus clock period equals processor cycle
// [R4] Strobes change only on bus clock edges
// [R5] Phases T1, T2, T3, T4 in order
// [R6] Half-period phases, T1 starts rising edge
// [R7] Wait states stretch T2 by whole periods
// [R8] Internal access: mirror address, strobes idle
// [R9] Bus granted away: all pins float; BUS_CLOCK_OUT has no enable and stays driven
// [R10] Address stable from T1 through T4
// [R11] Reads pick bytes inside; writes by strobes
// [R12] Memory read data valid in T4
// [R13] Memory releases bus by mid T1
// [R14] Write data driven T2 through T4
// [R15] Data held across chip select rise
// [R16] Data driven only when writing, used lanes
// [R17] Second byte cycle floats upper data lines
// [R18] Active-low strobe per lane, lane zero low
// [R19] Write strobes lead and track chip select
// [R20] Write strobes high between write cycles
// [R21] Chip select low on every external cycle
// [R22] Wait sampled in W2, repeats indefinitely
// [R23] Byte mode: low byte even, high odd
// [R24] Idle: chip select and strobes high
`default_nettype none
module esmb_ctrl
   import esmb_pkg::*;
#(
   parameter int PHASE_CYC_P = PHASE_CYC
) (
   input  wire logic              CLK_SYS,
   input  wire logic              ARST_N,
   input  wire logic              REQ_VALID,
   output logic                   REQ_READY,
   input  wire logic              REQ_WRITE,
   input  wire logic              REQ_INTERNAL,
   input  wire logic [ADDR_W-1:0] REQ_ADDR,
   input  wire logic [DATA_W-1:0] REQ_WDATA,
   input  wire logic [LANES-1:0]  REQ_BE,
   output logic                   RSP_VALID,
   output logic [DATA_W-1:0]      RSP_RDATA,
   input  wire logic              BYTE_LANE_MODE,
   input  wire logic              WAIT_REQUEST,
   input  wire logic              BUS_GRANT_AWAY,
   output logic                   BUS_CLOCK_OUT,
   output logic [ADDR_W-1:0]      EXT_ADDR_O,
   output logic                   EXT_ADDR_OE,
   input  wire logic [DATA_W-1:0] EXT_DATA_I,
   output logic [DATA_W-1:0]      EXT_DATA_O,
   output logic [LANES-1:0]       EXT_DATA_OE,
   output logic                   EXT_CS_N_O,
   output logic                   EXT_CS_N_OE,
   output logic [LANES-1:0]       EXT_WR_N_O,
   output logic                   EXT_WR_N_OE
);
   logic              phase_en;
   logic              bus_clk_high;
   esmb_state_t       state;
   esmb_state_t       next_state;
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W-1:0] next_addr;
   logic [DATA_W-1:0] dout;
   logic [DATA_W-1:0] next_dout;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] next_wdata;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] next_rdata;
   logic [LANES-1:0]  be;
   logic [LANES-1:0]  next_be;
   logic [LANES-1:0]  lanes;
   logic [LANES-1:0]  next_lanes;
   logic              wr;
   logic              next_wr;
   logic              byte_mode;
   logic              next_byte_mode;
   logic              second;
   logic              next_second;
   logic              rsp;
   logic              next_rsp;
   logic              accept;

   // Phase enables and bus clock from the divider
   esmb_phase_gen #(
      .PHASE_CYC_P (PHASE_CYC_P)
   ) u_phase (
      .clk          (CLK_SYS),
      .arst_n       (ARST_N),
      .phase_en     (phase_en),
      .bus_clk_high (bus_clk_high)
   );

   function automatic logic in_ext(input esmb_state_t s);
      return (s == ST_T1) || (s == ST_T2) || (s == ST_W1) ||
             (s == ST_W2) || (s == ST_T3) || (s == ST_T4);
   endfunction

   function automatic logic cs_phase(input esmb_state_t s);
      return (s == ST_T2) || (s == ST_W1) || (s == ST_W2) ||
             (s == ST_T3);
   endfunction

   // New work starts only at a phase boundary leading into a high half
   assign accept    = REQ_VALID && REQ_READY;
   assign REQ_READY = (state == ST_IDLE) && phase_en && !bus_clk_high &&
                      !BUS_GRANT_AWAY; // R6

   always_comb begin
      next_state     = state;
      next_addr      = addr;
      next_dout      = dout;
      next_wdata     = wdata;
      next_rdata     = rdata;
      next_be        = be;
      next_lanes     = lanes;
      next_wr        = wr;
      next_byte_mode = byte_mode;
      next_second    = second;
      next_rsp       = 1'b0;
      if (phase_en) begin
         unique case (state)
            ST_IDLE: begin
               if (BUS_GRANT_AWAY && !bus_clk_high) begin
                  next_state = ST_FLOAT; // R9
               end else if (accept) begin
                  next_addr      = {REQ_ADDR[ADDR_W-1:1], 1'b0}; // R1 R23
                  next_wr        = REQ_WRITE;
                  next_be        = REQ_BE;
                  next_lanes     = REQ_BE; // R18
                  next_wdata     = REQ_WDATA;
                  next_dout      = REQ_WDATA;
                  next_second    = 1'b0;
                  next_byte_mode = 1'b0;
                  next_state     = REQ_INTERNAL ? ST_INT1 : ST_T1; // R8
               end
            end
            ST_T1: next_state = ST_T2; // R5
            ST_T2: begin
               if (!second) begin
                  next_byte_mode = BYTE_LANE_MODE; // R2
               end
               next_state = WAIT_REQUEST ? ST_W1 : ST_T3; // R7
            end
            ST_W1: next_state = ST_W2;
            ST_W2: next_state = WAIT_REQUEST ? ST_W1 : ST_T3; // R22
            ST_T3: begin
               // Read data is taken as chip select rises
               if (!wr) begin
                  if (second) begin
                     next_rdata[DATA_W-1:BYTE_W] =
                        EXT_DATA_I[BYTE_W-1:0]; // R11 R12
                  end else if (byte_mode) begin
                     next_rdata[BYTE_W-1:0] = EXT_DATA_I[BYTE_W-1:0];
                  end else begin
                     next_rdata = EXT_DATA_I; // R11
                  end
               end
               next_state = ST_T4;
            end
            ST_T4: begin
               if (byte_mode && !second) begin
                  // Second byte cycle at the odd address on the low lane
                  next_second = 1'b1; // R23
                  next_addr   = {addr[ADDR_W-1:1], 1'b1};
                  next_dout   = {{BYTE_W{1'b0}}, wdata[DATA_W-1:BYTE_W]};
                  next_lanes  = {1'b0, be[1]}; // R17
                  next_state  = ST_T1;
               end else begin
                  next_rsp   = 1'b1;
                  next_state = ST_IDLE;
               end
            end
            ST_INT1: next_state = ST_INT2;
            ST_INT2: begin
               next_rsp   = 1'b1;
               next_state = ST_IDLE;
            end
            ST_FLOAT: begin
               if (!BUS_GRANT_AWAY && !bus_clk_high) begin
                  next_state = ST_IDLE;
               end
            end
            default: next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         state     <= ST_IDLE;
         addr      <= ADDR_RST;
         dout      <= '0;
         wdata     <= '0;
         rdata     <= '0;
         be        <= LANES_NONE;
         lanes     <= LANES_NONE;
         wr        <= 1'b0;
         byte_mode <= 1'b0;
         second    <= 1'b0;
         rsp       <= 1'b0;
      end else begin
         state     <= next_state;
         addr      <= next_addr;
         dout      <= next_dout;
         wdata     <= next_wdata;
         rdata     <= next_rdata;
         be        <= next_be;
         lanes     <= next_lanes;
         wr        <= next_wr;
         byte_mode <= next_byte_mode;
         second    <= next_second;
         rsp       <= next_rsp;
      end
   end

   assign RSP_VALID     = rsp;
   assign RSP_RDATA     = rdata;
   assign BUS_CLOCK_OUT = bus_clk_high; // R3

   // Pin drive decoded from registered state, so edges follow phases
   assign EXT_ADDR_O  = addr; // R10
   assign EXT_ADDR_OE = (state != ST_FLOAT); // R9
   assign EXT_DATA_O  = dout;
   assign EXT_DATA_OE = (wr && in_ext(state) && state != ST_T1) ?
                        lanes : LANES_NONE; // R14 R15 R16
   assign EXT_CS_N_O  = !cs_phase(state); // R21 R24 R4
   assign EXT_CS_N_OE = (state != ST_FLOAT);
   assign EXT_WR_N_O  = (wr && in_ext(state) && state != ST_T4) ?
                        ~lanes : STROBE_IDLE; // R18 R19 R20
   assign EXT_WR_N_OE = (state != ST_FLOAT);

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);

   AST_ADDR_STABLE: assert property ( // R10
      in_ext($past(state)) && in_ext(state) &&
      !(state == ST_T1 && $past(state) != ST_T1)
      |-> $stable(EXT_ADDR_O))
      else $error("Address moved inside an external cycle");

   AST_CS_ACTIVE: assert property ( // R21
      cs_phase(state) |-> !EXT_CS_N_O && EXT_CS_N_OE)
      else $error("Chip select not low during cycle");

   AST_WR_LEADS_CS: assert property ( // R19
      $fell(EXT_CS_N_O) |-> EXT_WR_N_O == $past(EXT_WR_N_O))
      else $error("Write strobe did not lead chip select");

   AST_WR_HIGH_T4: assert property ( // R20
      state == ST_T4 |-> EXT_WR_N_O == STROBE_IDLE)
      else $error("Write strobes not high in T4");

   AST_FLOAT_GRANT: assert property ( // R9
      state == ST_FLOAT |-> !EXT_ADDR_OE && !EXT_CS_N_OE &&
      !EXT_WR_N_OE && EXT_DATA_OE == LANES_NONE)
      else $error("Pins driven while bus granted away");

   AST_DATA_WRITE_ONLY: assert property ( // R16
      EXT_DATA_OE != LANES_NONE |-> wr && in_ext(state) &&
      state != ST_T1)
      else $error("Data bus driven outside a write");

   AST_INT_MIRROR: assert property ( // R8
      state == ST_INT1 || state == ST_INT2 |-> EXT_CS_N_O &&
      EXT_WR_N_O == STROBE_IDLE && EXT_DATA_OE == LANES_NONE &&
      EXT_ADDR_OE)
      else $error("Internal access disturbed the bus");

   AST_T1_RISE: assert property ( // R6
      state == ST_T1 && $past(state) != ST_T1 |-> BUS_CLOCK_OUT)
      else $error("T1 did not start on a rising edge");

   AST_WAIT_REPEAT: assert property ( // R22
      state == ST_W2 && phase_en && WAIT_REQUEST |=> state == ST_W1)
      else $error("Wait period not repeated");

   AST_BYTE2_UPPER: assert property ( // R17
      second && in_ext(state) |-> !EXT_DATA_OE[1] && EXT_WR_N_O[1] &&
      EXT_ADDR_O[0])
      else $error("Second byte cycle used upper lane");

   AST_BUS_CLK_TOGGLE: assert property ( // R3
      phase_en |=> BUS_CLOCK_OUT != $past(BUS_CLOCK_OUT))
      else $error("Bus clock did not toggle at a phase boundary");

   AST_DATA_HELD_CS_RISE: assert property ( // R15
      $rose(EXT_CS_N_O) && wr |-> EXT_DATA_OE == $past(EXT_DATA_OE) &&
      $stable(EXT_DATA_O))
      else $error("Write data moved as chip select rose");

   AST_IDLE_QUIET: assert property ( // R24
      state == ST_IDLE |-> EXT_CS_N_O && EXT_WR_N_O == STROBE_IDLE &&
      EXT_CS_N_OE && EXT_WR_N_OE)
      else $error("Strobes active while idle");

   COV_WRITE: cover property (state == ST_T4 && wr);
   COV_READ:  cover property (rsp && !wr);
   COV_WAIT:  cover property (state == ST_W2);
   COV_BYTE:  cover property (second && state == ST_T4);
   COV_GRANT: cover property (state == ST_FLOAT);
endmodule
`default_nettype wire

//--- dv/esmb_mem_model.sv
// Static RAM model on the far side of the external memory bus
`default_nettype none
module esmb_mem_model (
   input  wire logic        clk,
   input  wire logic        cs_n,
   input  wire logic        cs_oe,
   input  wire logic [1:0]  wr_n,
   input  wire logic [15:0] addr,
   input  wire logic [15:0] dout,
   input  wire logic [1:0]  doe,
   output logic      [15:0] bus
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [256];
   logic [15:0] last;
   logic [15:0] word;
   logic [15:0] drv;
   logic        cs_q;
   logic [1:0]  wr_q;
   logic        on;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
      last = 16'h0000;
      cs_q = 1'b1;
      wr_q = 2'h3;
   end
   always_comb begin
      word = mem[addr[8:1]];
      on = cs_oe && !cs_n && wr_n == 2'h3;
      // Released lines show a changing pattern, not the last value
      drv = !on ? ~last : addr[0] ? {~last[15:8], word[15:8]} : word;
      bus[7:0] = doe[0] ? dout[7:0] : drv[7:0];
      bus[15:8] = doe[1] ? dout[15:8] : drv[15:8];
   end
   always @(posedge clk) begin
      last <= bus;
      cs_q <= cs_n;
      wr_q <= wr_n;
      if (!cs_q && cs_n) begin
         if (addr[0]) begin
            if (!wr_q[0]) mem[addr[8:1]][15:8] <= bus[7:0];
         end else begin
            if (!wr_q[0]) mem[addr[8:1]][7:0] <= bus[7:0];
            if (!wr_q[1]) mem[addr[8:1]][15:8] <= bus[15:8];
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/esmb_bench.sv
// Testbench: directed and random traffic through the bus sequencer
`default_nettype none
module esmb_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 0, arst_n = 0, valid = 0, wr = 0, intl = 0;
   logic        bm = 0, wt = 0, away = 0;
   logic [15:0] addr = 16'h0000, wd = 16'h0000;
   logic [1:0]  be = 2'h3;
   logic        ready, rsp_v, bclk, a_oe, cs, cs_oe, wr_oe;
   logic [15:0] rdata, a_o, d_o, d_i;
   logic [1:0]  d_oe, wrn;
   int          err_total = 0, checks = 0, cyc = 0, seed = 90973;
   logic [15:0] sh [256];
   logic [16:0] q [$];
   logic [16:0] e;
   logic [31:0] r;
   logic        b0;

   always #5 clk = ~clk;

   esmb_ctrl i_esmb_ctrl (
      .CLK_SYS(clk), .ARST_N(arst_n), .REQ_VALID(valid), .REQ_READY(ready),
      .REQ_WRITE(wr), .REQ_INTERNAL(intl), .REQ_ADDR(addr), .REQ_WDATA(wd),
      .REQ_BE(be), .RSP_VALID(rsp_v), .RSP_RDATA(rdata),
      .BYTE_LANE_MODE(bm), .WAIT_REQUEST(wt), .BUS_GRANT_AWAY(away),
      .BUS_CLOCK_OUT(bclk), .EXT_ADDR_O(a_o), .EXT_ADDR_OE(a_oe),
      .EXT_DATA_I(d_i), .EXT_DATA_O(d_o), .EXT_DATA_OE(d_oe),
      .EXT_CS_N_O(cs), .EXT_CS_N_OE(cs_oe), .EXT_WR_N_O(wrn),
      .EXT_WR_N_OE(wr_oe));

   esmb_mem_model i_esmb_mem_model (
      .clk(clk), .cs_n(cs), .cs_oe(cs_oe), .wr_n(wrn), .addr(a_o),
      .dout(d_o), .doe(d_oe), .bus(d_i));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("errors %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Holds the request until taken, then notes the expected answer
   task automatic req(input logic w, i, m, input logic [15:0] a, d,
                      input logic [1:0] b);
      int n;
      n = 0;
      // Mode pin must stay put until the access in flight is done
      drain();
      @(posedge clk);
      #1;
      wr = w; intl = i; bm = m; addr = a; wd = d; be = b; valid = 1;
      @(negedge clk);
      while (ready !== 1'b1 && n < 300) begin
         n++;
         @(negedge clk);
      end
      if (ready !== 1'b1) err_total++;
      @(posedge clk);
      #1 valid = 0;
      if (w && !i && b[0]) sh[a[8:1]][7:0] = d[7:0];
      if (w && !i && b[1]) sh[a[8:1]][15:8] = d[15:8];
      q.push_back({!w && !i, sh[a[8:1]]});
   endtask

   task automatic drain;
      int n;
      n = 0;
      while (q.size() != 0 && n < 500) begin
         @(posedge clk);
         n++;
      end
      if (q.size() != 0) err_total++;
   endtask

   always @(posedge clk) begin
      #1 wt = ($random(seed) & 3) == 0;
   end

   always @(posedge clk) begin
      if (rsp_v === 1'b1) begin
         if (q.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            e = q.pop_front();
            if (e[16]) chk(rdata, e[15:0]);
         end
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end

   initial begin
      for (int i = 0; i < 256; i++) sh[i] = 16'h0000;
      repeat (16) @(posedge clk);
      #1 arst_n = 1;
      req(1, 0, 0, 16'h0010, 16'ha55a, 2'h3);
      req(0, 0, 0, 16'h0010, 16'h0000, 2'h3);
      req(1, 0, 1, 16'h0013, 16'h1234, 2'h3);
      req(0, 0, 1, 16'h0012, 16'h0000, 2'h3);
      req(1, 0, 0, 16'h0010, 16'hff00, 2'h2);
      req(1, 0, 1, 16'h0012, 16'h00ee, 2'h1);
      req(0, 0, 0, 16'h0010, 16'h0000, 2'h3);
      req(0, 0, 0, 16'h0012, 16'h0000, 2'h3);
      for (int k = 0; k < 60; k++) begin
         r = $random(seed);
         req(r[0], r[1] & r[2], r[3], $random(seed), $random(seed),
             r[5:4] == 2'h0 ? 2'h3 : r[5:4]);
      end
      req(0, 1, 0, 16'h8abc, 16'h0000, 2'h3);
      repeat (2) @(posedge clk);
      #1;
      chk({cs, wrn, d_oe, a_oe, a_o},
          {1'b1, 2'h3, 2'h0, 1'b1, 16'h8abc});
      drain();
      #1 away = 1;
      repeat (8) @(posedge clk);
      #1 chk({a_oe, d_oe, cs_oe, wr_oe, ready}, 32'h0);
      away = 0;
      repeat (8) @(posedge clk);
      #1 chk({cs, wrn, cs_oe, wr_oe}, {1'b1, 2'h3, 1'b1, 1'b1});
      b0 = bclk;
      repeat (esmb_pkg::PHASE_CYC) @(posedge clk);
      #1 chk(bclk, !b0);
      req(0, 0, 1, 16'h0010, 16'h0000, 2'h3);
      drain();
      chk(q.size(), 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
